// [shared/ubt_pkg.sv]
// Package for the upstream burst transmit encoder: register map,
// field layout, reset values, timing counts and state, bus and symbol types.
// Assumes a 250 MHz ref_clk and an APB master with 32-bit data.
package ubt_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEED = 8'h04;
    localparam logic [7:0] ADDR_PRE_LEN = 8'h08;
    localparam logic [7:0] ADDR_PRE_OFS = 8'h0C;
    localparam logic [7:0] ADDR_INFO_LEN = 8'h10;
    localparam logic [7:0] ADDR_FREQ = 8'h14;
    localparam logic [7:0] ADDR_PRE_PTR = 8'h18;
    localparam logic [7:0] ADDR_PRE_DATA = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // Control field positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_DIFF_BIT = 1;
    localparam int CTRL_SCRAM_BIT = 2;
    localparam int CTRL_SHORT_BIT = 3;
    localparam int CTRL_RATE_LSB = 4;
    localparam int CTRL_FEC_LSB = 8;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [14:0] SEED_RESET = 15'h0000;
    localparam logic [10:0] PRE_LEN_RESET = 11'h000;
    localparam logic [9:0] PRE_OFS_RESET = 10'h000;
    localparam logic [7:0] INFO_LEN_RESET = 8'h10;
    localparam logic [16:0] FREQ_RESET = 17'h00000;

    // Limits
    localparam logic [3:0] FEC_T_MAX = 4'hA;
    localparam logic [2:0] RATE_SEL_MAX = 3'h4;
    localparam logic [10:0] PRE_LEN_MAX = 11'h400;
    localparam int PAR_MAX = 20;
    localparam int PRE_WORDS = 32;
    localparam logic [7:0] GF_POLY_LOW = 8'h1D;
    localparam logic [7:0] GF_ALPHA = 8'h02;
    localparam logic [14:0] SCRAM_CLEAR = 15'h0000;
    localparam int ROLLOFF_PCT = 25;

    // Timing: symbol rate from a phase accumulator
    localparam longint CLK_HZ = 250000000;
    localparam longint SYM_RATE_MAX_HZ = 2560000;
    localparam logic [31:0] RATE_INC_MAX = 32'((SYM_RATE_MAX_HZ << 32) / CLK_HZ);
    localparam int FREQ_LIMIT_HZ = 32000;
    // Carrier step per Hz, scaled by 2^12: 2^44 / CLK_HZ
    localparam logic [16:0] HZ_STEP_Q12 = 17'((64'h1 << 44) / CLK_HZ);

    typedef enum logic [2:0] {
        S_IDLE, S_GEN, S_PRE, S_DATA, S_PAD, S_PAR, S_FLUSH, S_DONE
    } ubt_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ubt_apb_req_type;

    typedef struct packed {
        logic signed [3:0] i;
        logic signed [3:0] q;
    } ubt_sym_type;

endpackage

// [logic/ubt_encoder.sv]
// Upstream burst transmit encoder: RS encode, scramble, preamble
// prepend and QPSK/16QAM mapping, with an APB register slave.
// Assumes the MAC feeds bits on ref_clk and the modulator takes
// one symbol per sym_valid pulse.
//
// Contract
// - QPSK and 16QAM modes both selectable
// - Five symbol rates, 160 to 2560 ksym/s
// - Symbol rate never changes within a burst
// - Symbol bits serial, MSB first per mode
// - Differential quadrant rotation from previous MSBs
// - Carrier offset +-32 kHz, 1 Hz steps
// - Output is I cos minus Q sin
// - Root raised cosine shaping, 25 percent rolloff
// - RS over GF(256), T 1..10 or off
// - Generator roots alpha^0 .. alpha^(2T-1)
// - Field built on x8+x4+x3+x2+1
// - Codewords 18..255 bytes, uncoded from one; info_len is not range-checked
// - Optional shortened last codeword per burst
// - Correctable count loaded by software
// - First serial bit is byte MSB
// - Any 15-bit scrambler seed accepted
// - Scrambler cleared at reset, seeded each burst
// - Scrambler polynomial x15 + x14 + 1
// - Preamble bypasses FEC and scrambler
// - First preamble bit from offset, sent first
// - Preamble length even or multiple of four
// - Preamble length and content from software
// - Shared 1024-bit preamble pattern store
`timescale 1ns/1ps
`default_nettype none
module ubt_encoder
    import ubt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // APB slave
    input wire ubt_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // MAC bit stream
    input wire logic burst_start,
    input wire logic in_bit,
    input wire logic in_valid,
    input wire logic in_last,
    output logic in_ready,
    // Modulator side
    output ubt_sym_type sym_out,
    output logic sym_valid,
    output logic burst_active,
    output logic burst_done,
    output logic signed [31:0] carrier_step,
    output logic [2:0] sym_rate_sel,
    output logic [6:0] rolloff_pct
);

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int n = 0; n < 8; n++)
        begin
            if (b[n])
                p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY_LOW) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    // Quadrant index along the 90 degree cycle 11, 01, 00, 10
    function automatic logic [1:0] quad_index(input logic [1:0] q);
        case (q)
            2'b11: return 2'd0;
            2'b01: return 2'd1;
            2'b00: return 2'd2;
            default: return 2'd3;
        endcase
    endfunction

    function automatic ubt_sym_type sym_level(input logic qam16, input logic diff, input logic [3:0] b);
        ubt_sym_type s;
        logic mi;
        logic mq;
        mi = (diff && (b[3] ^ b[2])) ? b[0] : b[1];
        mq = (diff && (b[3] ^ b[2])) ? b[1] : b[0];
        if (!qam16)
        begin
            s.i = b[3] ? -4'sd1 : 4'sd1;
            s.q = b[2] ? -4'sd1 : 4'sd1;
        end
        else
        begin
            s.i = b[3] ? (mi ? -4'sd1 : -4'sd3) : (mi ? 4'sd1 : 4'sd3);
            s.q = b[2] ? (mq ? -4'sd1 : -4'sd3) : (mq ? 4'sd1 : 4'sd3);
        end
        return s;
    endfunction

    // Registers
    logic [31:0] ctrl;
    logic [14:0] seed;
    logic [10:0] pre_len;
    logic [9:0] pre_ofs;
    logic [7:0] info_len;
    logic signed [16:0] freq_hz;
    logic [4:0] pre_ptr;
    logic [31:0] pre_mem [0:PRE_WORDS-1];

    // Datapath state
    ubt_state_type state;
    logic [14:0] scr;
    logic [7:0] gpoly [0:PAR_MAX];
    logic [7:0] par [0:PAR_MAX-1];
    logic [7:0] alpha_pow;
    logic [4:0] gen_cnt;
    logic [10:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [6:0] byte_acc;
    logic last_seen;
    logic [3:0] asm_bits;
    logic [2:0] asm_cnt;
    logic [1:0] quad_prev;
    logic [31:0] phase_acc;

    // Configuration decode
    wire logic cfg_qam16 = ctrl[CTRL_MODE_BIT];
    wire logic cfg_diff = ctrl[CTRL_DIFF_BIT];
    wire logic cfg_scram = ctrl[CTRL_SCRAM_BIT];
    wire logic cfg_short = ctrl[CTRL_SHORT_BIT];
    wire logic [2:0] cfg_rate = ctrl[CTRL_RATE_LSB +: 3];
    wire logic [3:0] fec_t = ctrl[CTRL_FEC_LSB +: 4];
    wire logic fec_on = fec_t != 4'h0;
    wire logic [4:0] t2 = {fec_t, 1'b0};
    wire logic [10:0] pre_len_eff = cfg_qam16 ? {pre_len[10:2], 2'b00} : {pre_len[10:1], 1'b0};
    wire logic [2:0] bps = cfg_qam16 ? 3'd4 : 3'd2;
    wire logic busy = state != S_IDLE;

    // APB decode
    wire logic apb_setup = apb_req.psel && !apb_req.penable;
    wire logic apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire logic [7:0] pa = apb_req.paddr;
    wire logic [31:0] wd = apb_req.pwdata;
    wire logic addr_ok = pa <= ADDR_STATUS && pa[1:0] == 2'b00;
    wire logic [3:0] wr_t = (wd[CTRL_FEC_LSB +: 4] > FEC_T_MAX) ? FEC_T_MAX : wd[CTRL_FEC_LSB +: 4];
    wire logic [2:0] wr_rate_raw = wd[CTRL_RATE_LSB +: 3];
    wire logic [2:0] wr_rate = busy ? cfg_rate : ((wr_rate_raw > RATE_SEL_MAX) ? RATE_SEL_MAX : wr_rate_raw);
    wire logic signed [16:0] wr_hz = wd[16:0];
    wire logic signed [16:0] hz_lim = 17'(FREQ_LIMIT_HZ);
    wire logic signed [16:0] wr_hz_clip = (wr_hz > hz_lim) ? hz_lim : ((wr_hz < -hz_lim) ? -hz_lim : wr_hz);
    wire logic [31:0] status_word = {20'h0, 1'b0, asm_cnt, last_seen, 3'(state), 3'b000, busy};

    always_comb
    begin
        case (pa)
            ADDR_CTRL: prdata = ctrl;
            ADDR_SEED: prdata = {17'h0, seed};
            ADDR_PRE_LEN: prdata = {21'h0, pre_len};
            ADDR_PRE_OFS: prdata = {22'h0, pre_ofs};
            ADDR_INFO_LEN: prdata = {24'h0, info_len};
            ADDR_FREQ: prdata = {{15{freq_hz[16]}}, freq_hz};
            ADDR_PRE_PTR: prdata = {27'h0, pre_ptr};
            ADDR_PRE_DATA: prdata = pre_mem[pre_ptr];
            ADDR_STATUS: prdata = status_word;
            default: prdata = 32'h0000_0000;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= CTRL_RESET;
            seed <= SEED_RESET;
            pre_len <= PRE_LEN_RESET;
            pre_ofs <= PRE_OFS_RESET;
            info_len <= INFO_LEN_RESET;
            freq_hz <= FREQ_RESET;
            pre_ptr <= 5'h00;
        end
        else if (apb_wr)
        begin
            case (pa)
                ADDR_CTRL: ctrl <= {20'h0, wr_t, 1'b0, wr_rate, wd[3:0]};
                ADDR_SEED: seed <= wd[14:0];
                ADDR_PRE_LEN: pre_len <= (wd[10:0] > PRE_LEN_MAX) ? PRE_LEN_MAX : wd[10:0];
                ADDR_PRE_OFS: pre_ofs <= wd[9:0];
                ADDR_INFO_LEN: info_len <= wd[7:0];
                ADDR_FREQ: freq_hz <= wr_hz_clip;
                ADDR_PRE_PTR: pre_ptr <= wd[4:0];
                ADDR_PRE_DATA: pre_ptr <= pre_ptr + 5'h01;
                default: ;
            endcase
        end
    end

    // Preamble pattern store, no reset
    always_ff @(posedge ref_clk)
    begin
        if (apb_wr && pa == ADDR_PRE_DATA)
            pre_mem[pre_ptr] <= wd;
    end

    // Symbol-rate enable from a phase accumulator
    wire logic [31:0] rate_inc = RATE_INC_MAX >> (RATE_SEL_MAX - cfg_rate);
    wire logic [32:0] next_acc = {1'b0, phase_acc} + {1'b0, rate_inc};
    wire logic sym_tick = next_acc[32];

    // Bit source selection
    wire logic asm_full = asm_cnt == bps;
    wire logic [9:0] pre_bit_addr = pre_ofs + bit_cnt[9:0];
    wire logic [31:0] pre_word = pre_mem[pre_bit_addr[9:5]];
    wire logic pre_bit = pre_word[5'd31 - pre_bit_addr[4:0]];
    wire logic [7:0] par_top = par[t2 - 5'd1];
    wire logic [2:0] bit_in_byte = bit_cnt[2:0];
    wire logic take_in = state == S_DATA && in_valid && !asm_full;
    wire logic push_pad = state == S_PAD && !asm_full;
    wire logic push_par = state == S_PAR && !asm_full;
    wire logic push_pre = state == S_PRE && !asm_full;
    wire logic push_flush = state == S_FLUSH && asm_cnt != 3'd0 && !asm_full;
    wire logic data_push = take_in || push_pad || push_par;
    wire logic push = data_push || push_pre || push_flush;
    wire logic raw_bit = take_in ? in_bit : (push_par ? par_top[3'd7 - bit_in_byte] : 1'b0);
    wire logic scr_out = scr[13] ^ scr[14];
    wire logic scr_shift = data_push && cfg_scram;
    wire logic data_bit = raw_bit ^ (cfg_scram & scr_out);
    wire logic out_bit = push_pre ? pre_bit : data_bit;
    wire logic byte_end = (take_in || push_pad) && bit_in_byte == 3'd7;
    wire logic [7:0] full_byte = {byte_acc, take_in ? in_bit : 1'b0};
    wire logic last_now = last_seen || (take_in && in_last);
    wire logic block_full = byte_cnt + 8'd1 == info_len;
    wire logic par_end = push_par && bit_in_byte == 3'd7 && byte_cnt + 8'd1 == {3'b000, t2};

    // RS generator build and parity update
    wire logic [7:0] fb = full_byte ^ par[t2 - 5'd1];
    logic [7:0] next_g [0:PAR_MAX];
    logic [7:0] next_par [0:PAR_MAX-1];
    genvar gj;
    generate
        for (gj = 0; gj <= PAR_MAX; gj++)
        begin : g_gen
            if (gj == 0)
                assign next_g[gj] = gf_mul(gpoly[gj], alpha_pow);
            else
                assign next_g[gj] = gpoly[gj-1] ^ gf_mul(gpoly[gj], alpha_pow);
        end
        for (gj = 0; gj < PAR_MAX; gj++)
        begin : g_par
            if (gj == 0)
                assign next_par[gj] = push_par ? 8'h00 : gf_mul(fb, gpoly[gj]);
            else
                assign next_par[gj] = push_par ? par[gj-1] : (par[gj-1] ^ gf_mul(fb, gpoly[gj]));
        end
    endgenerate

    // Burst sequencing
    ubt_state_type next_state;
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE: if (burst_start) next_state = S_GEN;
            S_GEN: if (!fec_on || gen_cnt == t2) next_state = (pre_len_eff != 11'h0) ? S_PRE : S_DATA;
            S_PRE: if (push_pre && bit_cnt + 11'd1 == pre_len_eff) next_state = S_DATA;
            S_DATA, S_PAD:
                if (byte_end)
                begin
                    if (!fec_on)
                        next_state = last_now ? S_FLUSH : S_DATA;
                    else if (block_full || (last_now && cfg_short))
                        next_state = S_PAR;
                    else if (last_now)
                        next_state = S_PAD;
                end
            S_PAR: if (par_end) next_state = last_seen ? S_FLUSH : S_DATA;
            S_FLUSH: if (asm_cnt == 3'd0) next_state = S_DONE;
            S_DONE: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    wire logic phase_change = next_state != state;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= S_IDLE;
            bit_cnt <= 11'h000;
            byte_cnt <= 8'h00;
            byte_acc <= 7'h00;
            last_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == S_IDLE)
                last_seen <= 1'b0;
            else if (take_in && in_last)
                last_seen <= 1'b1;
            if (phase_change && next_state != S_PAD)
                bit_cnt <= 11'h000;
            else if (push && state != S_FLUSH)
                bit_cnt <= bit_cnt + 11'd1;
            if (phase_change && next_state != S_PAD)
                byte_cnt <= 8'h00;
            else if (byte_end || (push_par && bit_in_byte == 3'd7))
                byte_cnt <= byte_cnt + 8'd1;
            if (take_in || push_pad)
                byte_acc <= full_byte[6:0];
        end
    end

    integer k;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alpha_pow <= 8'h01;
            gen_cnt <= 5'h00;
            for (k = 0; k <= PAR_MAX; k++)
                gpoly[k] <= 8'h00;
            for (k = 0; k < PAR_MAX; k++)
                par[k] <= 8'h00;
        end
        else if (state == S_IDLE && burst_start)
        begin
            alpha_pow <= 8'h01;
            gen_cnt <= 5'h00;
            gpoly[0] <= 8'h01;
            for (k = 1; k <= PAR_MAX; k++)
                gpoly[k] <= 8'h00;
            for (k = 0; k < PAR_MAX; k++)
                par[k] <= 8'h00;
        end
        else if (state == S_GEN && gen_cnt != t2)
        begin
            alpha_pow <= gf_mul(alpha_pow, GF_ALPHA);
            gen_cnt <= gen_cnt + 5'd1;
            for (k = 0; k <= PAR_MAX; k++)
                gpoly[k] <= next_g[k];
        end
        else if (fec_on && (byte_end || push_par && bit_in_byte == 3'd7))
        begin
            for (k = 0; k < PAR_MAX; k++)
                par[k] <= next_par[k];
        end
    end

    // Scrambler: cleared at reset, seeded at burst start
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            scr <= SCRAM_CLEAR;
        else if (state == S_IDLE && burst_start)
            scr <= seed;
        else if (scr_shift)
            scr <= {scr[13:0], scr_out};
    end

    // Symbol assembly, differential quadrant, mapping
    wire logic [3:0] next_asm = cfg_qam16 ? {asm_bits[2:0], out_bit} : {asm_bits[2], out_bit, 2'b00};
    wire logic [1:0] rot = asm_bits[3:2];
    // Input bits 00, 01, 11, 10 turn by 0 to 3 quarter steps
    wire logic [1:0] rot_steps = {rot[1], rot[1] ^ rot[0]};
    wire logic [1:0] qidx = quad_index(quad_prev) + rot_steps;
    logic [1:0] quad_new;
    always_comb
    begin
        case (qidx)
            2'd0: quad_new = 2'b11;
            2'd1: quad_new = 2'b01;
            2'd2: quad_new = 2'b00;
            default: quad_new = 2'b10;
        endcase
    end
    wire logic [1:0] quad_use = cfg_diff ? quad_new : rot;
    wire logic quad_load = sym_tick && asm_full;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            asm_bits <= 4'h0;
            asm_cnt <= 3'd0;
            quad_prev <= 2'b11;
            phase_acc <= 32'h0000_0000;
            sym_out <= '0;
            sym_valid <= 1'b0;
        end
        else
        begin
            phase_acc <= next_acc[31:0];
            sym_valid <= quad_load;
            if (state == S_IDLE)
                quad_prev <= 2'b11;
            else if (quad_load)
                quad_prev <= quad_use;
            if (quad_load)
            begin
                sym_out <= sym_level(cfg_qam16, cfg_diff, {quad_use, asm_bits[1:0]});
                asm_cnt <= 3'd0;
            end
            else if (push)
            begin
                asm_bits <= next_asm;
                asm_cnt <= asm_cnt + 3'd1;
            end
        end
    end

    // Carrier offset step for the modulator
    wire logic signed [33:0] step_prod = freq_hz * $signed({1'b0, HZ_STEP_Q12});
    assign carrier_step = 32'(step_prod >>> 12);
    assign sym_rate_sel = cfg_rate;
    assign rolloff_pct = 7'(ROLLOFF_PCT);
    assign in_ready = state == S_DATA && !asm_full;
    assign burst_active = busy;
    assign burst_done = state == S_DONE;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_burst_go;
        state == S_IDLE && burst_start;
    endsequence
    sequence s_block_close;
        fec_on && byte_end && block_full;
    endsequence

    a_seed_load: assert property (s_burst_go |=> scr == seed)
        else $error("scrambler not seeded at burst start");
    a_lfsr_step: assert property (scr_shift && state != S_IDLE |=> scr == {$past(scr[13:0]), $past(scr_out)})
        else $error("scrambler step wrong");
    a_pre_bypass: assert property (push_pre |=> $stable(scr))
        else $error("preamble bit moved scrambler");
    a_rate_hold: assert property (busy && $past(busy) |-> $stable(cfg_rate))
        else $error("symbol rate changed in burst");
    a_diff_keep: assert property (quad_load && cfg_diff && rot == 2'b00 |=> quad_prev == $past(quad_prev))
        else $error("zero rotation moved quadrant");
    a_gen_length: assert property (s_burst_go ##1 fec_on |-> ##[1:20] gen_cnt == t2)
        else $error("generator build too long");
    a_t_range: assert property (fec_t <= FEC_T_MAX)
        else $error("correctable count out of range");
    a_block_parity: assert property (s_block_close |=> state == S_PAR)
        else $error("full block not followed by parity");
    a_sym_on_tick: assert property (sym_valid |-> $past(sym_tick) && $past(asm_cnt) == $past(bps))
        else $error("symbol left without full bits");
    a_pre_align: assert property (push_pre && next_state == S_DATA |-> asm_cnt + 3'd1 == bps)
        else $error("preamble not symbol aligned");

endmodule
`default_nettype wire

// [verif/ubt_mac_model.sv]
// MAC bit source and symbol sink on the encoder's stream side.
// Assumes the encoder's valid/ready stream contract on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ubt_mac_model
    import ubt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic slow,
    // Encoder stream
    input wire logic in_ready,
    input wire ubt_sym_type sym_out,
    input wire logic sym_valid,
    output logic in_bit = 1'b0,
    output logic in_valid = 1'b0,
    output logic in_last = 1'b0
);
    logic bits_q[$];
    ubt_sym_type rx_q[$];

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_valid <= 1'b0;
            in_last <= 1'b0;
        end
        else
        begin
            if (sym_valid)
                rx_q.push_back(sym_out);
            if (!in_valid || in_ready)
            begin
                // Idle line toggles; slow mode gaps after each bit
                in_valid <= bits_q.size() > 0 && !(slow && in_valid);
                in_last <= bits_q.size() == 1;
                in_bit <= (bits_q.size() > 0 && !(slow && in_valid)) ? bits_q.pop_front() : ~in_bit;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/tb_upstream_burst_tx_encoder.sv]
// Self-checking bench: APB register checks and five bursts.
// Assumes the encoder's APB contract and the MAC model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_upstream_burst_tx_encoder import ubt_pkg::*;;
    localparam logic [31:0] PAT = 32'hB4C3_1E5A;
    localparam logic [1:0] CYC [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic burst_start = 1'b0;
    logic slow = 1'b0;
    ubt_apb_req_type apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, in_bit, in_valid, in_last, in_ready, sym_valid, burst_active, burst_done;
    ubt_sym_type sym_out;
    logic signed [31:0] carrier_step;
    logic [2:0] sym_rate_sel;
    logic [6:0] rolloff_pct;
    logic [7:0] msg[$];
    logic eb[$];
    ubt_sym_type xq[$];
    int n_errors = 0;
    int total_checks = 0;

    always #2 ref_clk = ~ref_clk;

    ubt_encoder u_dut (.ref_clk, .reset_n, .apb_req, .prdata, .pready, .pslverr, .burst_start, .in_bit,
        .in_valid, .in_last, .in_ready, .sym_out, .sym_valid, .burst_active, .burst_done, .carrier_step,
        .sym_rate_sel, .rolloff_pct);
    ubt_mac_model u_mac (.ref_clk, .reset_n, .slow, .in_ready, .sym_out, .sym_valid, .in_bit, .in_valid,
        .in_last);

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            n_errors++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        apb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, x, r);
        check({nm, " error flag"}, 32'(xe), 32'(e));
    endtask

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
        end
        return p;
    endfunction

    task automatic burst(input logic [31:0] c, input logic [10:0] pl, input logic [9:0] po,
        input logic [14:0] sd, input string nm);
        logic [14:0] s;
        logic [7:0] p1, p0, fb;
        logic [3:0] b;
        logic [1:0] pm;
        ubt_sym_type e;
        int n;
        wr(ADDR_CTRL, c);
        wr(ADDR_PRE_LEN, 32'(pl));
        wr(ADDR_PRE_OFS, 32'(po));
        wr(ADDR_SEED, 32'(sd));
        eb = {};
        for (int i = 0; i < pl; i++)
            eb.push_back(PAT[31 - (int'(po) + i) % 32]);
        s = sd;
        p1 = 8'h00;
        p0 = 8'h00;
        n = msg.size();
        while (c[8] && !c[3] && msg.size() < INFO_LEN_RESET)
            msg.push_back(8'h00);
        foreach (msg[j])
        begin
            fb = msg[j] ^ p1;
            p1 = p0 ^ gmul(fb, 8'h03);
            p0 = gmul(fb, 8'h02);
            for (int i = 7; i >= 0; i--)
                if (j < n)
                    u_mac.bits_q.push_back(msg[j][i]);
        end
        if (c[8])
            msg.push_back(p1);
        if (c[8])
            msg.push_back(p0);
        foreach (msg[j])
            for (int i = 7; i >= 0; i--)
            begin
                eb.push_back(msg[j][i] ^ (c[2] & (s[13] ^ s[14])));
                s = {s[13:0], s[13] ^ s[14]};
            end
        pm = 2'b11;
        for (int i = 0; i < eb.size(); i += (c[0] ? 4 : 2))
        begin
            b = c[0] ? {eb[i], eb[i + 1], eb[i + 2], eb[i + 3]} : {eb[i], eb[i + 1], 2'b00};
            if (c[1])
                b[3:2] = CYC[2'({~pm[0], pm[1] ^ pm[0]} + {b[3], b[3] ^ b[2]})];
            pm = b[3:2];
            if (c[1] && (b[3] ^ b[2]))
                b[1:0] = {b[0], b[1]};
            e.i = (c[0] && !b[1]) ? 4'sh3 : 4'sh1;
            e.q = (c[0] && !b[0]) ? 4'sh3 : 4'sh1;
            if (b[3])
                e.i = -e.i;
            if (b[2])
                e.q = -e.q;
            xq.push_back(e);
        end
        slow <= c[0];
        burst_start <= 1'b1;
        @(posedge ref_clk);
        burst_start <= 1'b0;
        n = 0;
        while (burst_done !== 1'b1 && n < 30000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 30000)
        begin
            n_errors++;
            stop_test();
        end
        check({nm, " active"}, 32'h1, 32'(burst_active));
        check({nm, " count"}, xq.size(), u_mac.rx_q.size());
        foreach (xq[j])
            check({nm, " symbol"}, 32'(xq[j]), 32'(u_mac.rx_q[j]));
        xq = {};
        u_mac.rx_q = {};
        @(posedge ref_clk);
        $display("test %s done", nm);
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(ADDR_CTRL, CTRL_RESET, 1'b0, "ctrl reset");
        rd(ADDR_INFO_LEN, 32'h10, 1'b0, "k reset");
        rd(8'h24, 32'h0, 1'b1, "unmapped");
        wr(ADDR_CTRL, 32'h0F74);
        rd(ADDR_CTRL, 32'h0A44, 1'b0, "ctrl clamp");
        check("rate select", 32'h4, 32'(sym_rate_sel));
        check("rolloff", 32'h19, 32'(rolloff_pct));
        wr(ADDR_FREQ, 32'h9C40);
        rd(ADDR_FREQ, 32'h7D00, 1'b0, "freq clamp");
        check("carrier step", 32'h1, 32'(carrier_step > 32'sh862D0 && carrier_step < 32'sh86428));
        wr(ADDR_PRE_PTR, 32'h1F);
        wr(ADDR_PRE_DATA, PAT);
        wr(ADDR_PRE_DATA, PAT);
        wr(ADDR_PRE_PTR, 32'h0);
        rd(ADDR_PRE_DATA, PAT, 1'b0, "pattern");
        $display("test registers done");
        msg = '{8'h2D};
        burst(32'h0040, 11'h008, 10'h3FC, 15'h0000, "qpsk wrap");
        msg = '{8'hC3, 8'h7E};
        burst(32'h0045, 11'h008, 10'h000, 15'h4A5B, "qam scram");
        msg = '{8'h96};
        burst(32'h0042, 11'h004, 10'h000, 15'h0000, "diff");
        wr(ADDR_INFO_LEN, 32'h10);
        msg = '{8'h01, 8'hA5, 8'hFF};
        burst(32'h0149, 11'h000, 10'h000, 15'h0000, "rs short");
        msg = '{8'h5A};
        burst(32'h0147, 11'h000, 10'h000, 15'h1234, "rs pad diff");
        stop_test();
    end
endmodule
`default_nettype wire
